/* File: logic/cfg_latch_regs.svh */
// Purpose: constants for the configuration latch interface
// Assumes: one 125 MHz clock, active-low asynchronous reset
// Notes: offsets are bank addresses on the 3-bit address bus
// Behaviour
// - six write-only seven-bit banks, no readback
// - strobe low latches data into addressed bank
// - banks 0,1,2 channel A; static/dynamic split
// - rate select resets 1: half-rate clocks
// - rate select 0: full character-rate clocks
// - primary detect amplitude resets to 10
// - secondary detect amplitude resets to 10
// - training multiplier resets 0, 1 doubles
// - receive channel enable resets 0, powered down
// - selftest select resets 11; 01 smpte, 10 bist
// - primary retimed enable resets 0, disabled
// - secondary retimed enable resets 0, disabled
// - both enables zero powers down reclocker logic
// - reset clears every retimed output enable
// - banks 5,6,7 channel B, same layout
// - reset returns all latches to initial values
`ifndef CFG_LATCH_REGS_SVH
`define CFG_LATCH_REGS_SVH

`define CFG_ADDR_W 3
`define CFG_DATA_W 7

`define CFG_A_STATIC0 3'h0
`define CFG_A_STATIC1 3'h1
`define CFG_A_DYNAMIC 3'h2
`define CFG_TEST3 3'h3
`define CFG_TEST4 3'h4
`define CFG_B_STATIC0 3'h5
`define CFG_B_STATIC1 3'h6
`define CFG_B_DYNAMIC 3'h7

// static bank 0 fields
`define FLD_RATE_SEL 0
// static bank 1 fields
`define FLD_TRG_MULT 0
`define FLD_DET1_LO 3
`define FLD_DET1_HI 4
`define FLD_DET2_LO 5
`define FLD_DET2_HI 6
// dynamic bank fields
`define FLD_ROE1 1
`define FLD_ROE2 2
`define FLD_BIST_LO 4
`define FLD_PWR_EN 5
`define FLD_BIST_HI 6

`define RST_RATE_SEL 1'h1
`define RST_DET_AMP 2'h2
`define RST_TRG_MULT 1'h0
`define RST_PWR_EN 1'h0
`define RST_BIST_SEL 2'h3
`define RST_ROE 1'h0

`define BIST_SMPTE 2'h1
`define BIST_PATTERN 2'h2

`endif

/* File: logic/cfg_latch_pkg.sv */
// Purpose: types for the configuration latch interface
// Assumes: used together with cfg_latch_regs.svh
// Notes: selftest mode decode type only
package cfg_latch_pkg;
	typedef enum logic [1:0] {
		sel_invalid_lo,
		sel_smpte,
		sel_pattern,
		sel_invalid_hi
	} selftest_mode_t;
endpackage

/* File: logic/config_latch_interface.sv */
// Purpose: write-only configuration latches for a two-channel deserializer
// Assumes: strobe, address and data synchronous to clock
// Notes: only decoded control bits are kept; fixed and don't-care bits are dropped
`timescale 1ns/10ps
`include "cfg_latch_regs.svh"
`default_nettype none

module config_latch_interface (
	input wire logic clock,
	input wire logic rstn,
	input wire logic config_write_strobe_n,
	input wire logic [`CFG_ADDR_W-1:0] config_addr,
	input wire logic [`CFG_DATA_W-1:0] config_data,
	output logic [1:0] recovered_clock_rate_sel,
	output logic [1:0] half_rate_clock_mode,
	output logic [3:0] primary_detect_amplitude,
	output logic [3:0] secondary_detect_amplitude,
	output logic [1:0] primary_detector_enable,
	output logic [1:0] secondary_detector_enable,
	output logic [1:0] training_clock_multiplier,
	output logic [1:0] receive_channel_power_enable,
	output logic [3:0] receive_selftest_select,
	output cfg_latch_pkg::selftest_mode_t selftest_mode_a,
	output cfg_latch_pkg::selftest_mode_t selftest_mode_b,
	output logic [1:0] primary_retimed_out_enable,
	output logic [1:0] secondary_retimed_out_enable,
	output logic [1:0] reclocker_logic_power_enable
);
	import cfg_latch_pkg::*;

	// suffix a is channel A, b is channel B; fixed and don't-care bits are not kept
	logic wr;
	logic hit_a_static0, hit_a_static1, hit_a_dynamic;
	logic hit_b_static0, hit_b_static1, hit_b_dynamic;

	logic rate_a_ff, nxt_rate_a, rate_b_ff, nxt_rate_b;
	logic mult_a_ff, nxt_mult_a, mult_b_ff, nxt_mult_b;
	logic [1:0] det1_a_ff, nxt_det1_a, det1_b_ff, nxt_det1_b;
	logic [1:0] det2_a_ff, nxt_det2_a, det2_b_ff, nxt_det2_b;
	logic roe1_a_ff, nxt_roe1_a, roe1_b_ff, nxt_roe1_b;
	logic roe2_a_ff, nxt_roe2_a, roe2_b_ff, nxt_roe2_b;
	logic pwr_a_ff, nxt_pwr_a, pwr_b_ff, nxt_pwr_b;
	logic [1:0] bist_a_ff, nxt_bist_a, bist_b_ff, nxt_bist_b;

	// decoded copies registered too, so every port comes from a flip-flop
	logic half_a_ff, nxt_half_a, half_b_ff, nxt_half_b;
	logic den1_a_ff, nxt_den1_a, den1_b_ff, nxt_den1_b;
	logic den2_a_ff, nxt_den2_a, den2_b_ff, nxt_den2_b;
	logic rclk_pwr_a_ff, nxt_rclk_pwr_a, rclk_pwr_b_ff, nxt_rclk_pwr_b;
	selftest_mode_t mode_a_ff, nxt_mode_a, mode_b_ff, nxt_mode_b;

	// level-sensitive latch modelled as capture on each clock while strobe low,
	// so a strobe held low rewrites the bank every cycle
	assign wr = ~config_write_strobe_n;

	// one-hot bank select; test addresses 3 and 4 hit nothing, writes there drop
	always_comb begin
		hit_a_static0 = 1'h0;
		hit_a_static1 = 1'h0;
		hit_a_dynamic = 1'h0;
		hit_b_static0 = 1'h0;
		hit_b_static1 = 1'h0;
		hit_b_dynamic = 1'h0;
		if (wr) begin
			if (config_addr == `CFG_A_STATIC0) begin
				hit_a_static0 = 1'h1;
			end else if (config_addr == `CFG_A_STATIC1) begin
				hit_a_static1 = 1'h1;
			end else if (config_addr == `CFG_A_DYNAMIC) begin
				hit_a_dynamic = 1'h1;
			end else if (config_addr == `CFG_B_STATIC0) begin
				hit_b_static0 = 1'h1;
			end else if (config_addr == `CFG_B_STATIC1) begin
				hit_b_static1 = 1'h1;
			end else if (config_addr == `CFG_B_DYNAMIC) begin
				hit_b_dynamic = 1'h1;
			end
		end
	end

	// channel A static bank 0
	always_comb begin
		nxt_rate_a = rate_a_ff; // hold unless this bank is hit
		if (hit_a_static0) begin
			nxt_rate_a = config_data[`FLD_RATE_SEL];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rate_a_ff <= `RST_RATE_SEL;
		end else begin
			rate_a_ff <= nxt_rate_a;
		end
	end

	// channel A static bank 1
	// multiplier 1 needs speed select high; left to the host, not checked here
	always_comb begin
		nxt_mult_a = mult_a_ff;
		nxt_det1_a = det1_a_ff;
		nxt_det2_a = det2_a_ff;
		if (hit_a_static1) begin
			nxt_mult_a = config_data[`FLD_TRG_MULT];
			nxt_det1_a = config_data[`FLD_DET1_HI:`FLD_DET1_LO];
			nxt_det2_a = config_data[`FLD_DET2_HI:`FLD_DET2_LO];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mult_a_ff <= `RST_TRG_MULT;
			det1_a_ff <= `RST_DET_AMP;
			det2_a_ff <= `RST_DET_AMP;
		end else begin
			mult_a_ff <= nxt_mult_a;
			det1_a_ff <= nxt_det1_a;
			det2_a_ff <= nxt_det2_a;
		end
	end

	// channel A dynamic bank
	always_comb begin
		nxt_roe1_a = roe1_a_ff;
		nxt_roe2_a = roe2_a_ff;
		nxt_pwr_a = pwr_a_ff;
		nxt_bist_a = bist_a_ff;
		if (hit_a_dynamic) begin
			nxt_roe1_a = config_data[`FLD_ROE1];
			nxt_roe2_a = config_data[`FLD_ROE2];
			nxt_pwr_a = config_data[`FLD_PWR_EN];
			nxt_bist_a = {config_data[`FLD_BIST_HI], config_data[`FLD_BIST_LO]};
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			roe1_a_ff <= `RST_ROE;
			roe2_a_ff <= `RST_ROE;
			pwr_a_ff <= `RST_PWR_EN;
			bist_a_ff <= `RST_BIST_SEL;
		end else begin
			roe1_a_ff <= nxt_roe1_a;
			roe2_a_ff <= nxt_roe2_a;
			pwr_a_ff <= nxt_pwr_a;
			bist_a_ff <= nxt_bist_a;
		end
	end

	// channel A clock and detector decode, from next values so it moves with the latch
	always_comb begin
		nxt_half_a = nxt_rate_a; // 1 half rate, 0 full rate
		nxt_den1_a = |nxt_det1_a; // code 00 disables
		nxt_den2_a = |nxt_det2_a;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			half_a_ff <= `RST_RATE_SEL;
			den1_a_ff <= |`RST_DET_AMP;
			den2_a_ff <= |`RST_DET_AMP;
		end else begin
			half_a_ff <= nxt_half_a;
			den1_a_ff <= nxt_den1_a;
			den2_a_ff <= nxt_den2_a;
		end
	end

	// channel A power and selftest decode
	// reserved selftest codes are stored as written; the decode marks them invalid
	always_comb begin
		nxt_rclk_pwr_a = nxt_roe1_a | nxt_roe2_a;
		nxt_mode_a = selftest_mode_t'(nxt_bist_a);
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rclk_pwr_a_ff <= `RST_ROE;
			mode_a_ff <= selftest_mode_t'(`RST_BIST_SEL);
		end else begin
			rclk_pwr_a_ff <= nxt_rclk_pwr_a;
			mode_a_ff <= nxt_mode_a;
		end
	end

	// channel B static bank 0, same layout as channel A
	always_comb begin
		nxt_rate_b = rate_b_ff;
		if (hit_b_static0) begin
			nxt_rate_b = config_data[`FLD_RATE_SEL];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rate_b_ff <= `RST_RATE_SEL;
		end else begin
			rate_b_ff <= nxt_rate_b;
		end
	end

	// channel B static bank 1
	always_comb begin
		nxt_mult_b = mult_b_ff;
		nxt_det1_b = det1_b_ff;
		nxt_det2_b = det2_b_ff;
		if (hit_b_static1) begin
			nxt_mult_b = config_data[`FLD_TRG_MULT];
			nxt_det1_b = config_data[`FLD_DET1_HI:`FLD_DET1_LO];
			nxt_det2_b = config_data[`FLD_DET2_HI:`FLD_DET2_LO];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mult_b_ff <= `RST_TRG_MULT;
			det1_b_ff <= `RST_DET_AMP;
			det2_b_ff <= `RST_DET_AMP;
		end else begin
			mult_b_ff <= nxt_mult_b;
			det1_b_ff <= nxt_det1_b;
			det2_b_ff <= nxt_det2_b;
		end
	end

	// channel B dynamic bank
	always_comb begin
		nxt_roe1_b = roe1_b_ff;
		nxt_roe2_b = roe2_b_ff;
		nxt_pwr_b = pwr_b_ff;
		nxt_bist_b = bist_b_ff;
		if (hit_b_dynamic) begin
			nxt_roe1_b = config_data[`FLD_ROE1];
			nxt_roe2_b = config_data[`FLD_ROE2];
			nxt_pwr_b = config_data[`FLD_PWR_EN];
			nxt_bist_b = {config_data[`FLD_BIST_HI], config_data[`FLD_BIST_LO]};
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			roe1_b_ff <= `RST_ROE;
			roe2_b_ff <= `RST_ROE;
			pwr_b_ff <= `RST_PWR_EN;
			bist_b_ff <= `RST_BIST_SEL;
		end else begin
			roe1_b_ff <= nxt_roe1_b;
			roe2_b_ff <= nxt_roe2_b;
			pwr_b_ff <= nxt_pwr_b;
			bist_b_ff <= nxt_bist_b;
		end
	end

	// channel B clock and detector decode
	always_comb begin
		nxt_half_b = nxt_rate_b;
		nxt_den1_b = |nxt_det1_b;
		nxt_den2_b = |nxt_det2_b;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			half_b_ff <= `RST_RATE_SEL;
			den1_b_ff <= |`RST_DET_AMP;
			den2_b_ff <= |`RST_DET_AMP;
		end else begin
			half_b_ff <= nxt_half_b;
			den1_b_ff <= nxt_den1_b;
			den2_b_ff <= nxt_den2_b;
		end
	end

	// channel B power and selftest decode
	always_comb begin
		nxt_rclk_pwr_b = nxt_roe1_b | nxt_roe2_b;
		nxt_mode_b = selftest_mode_t'(nxt_bist_b);
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rclk_pwr_b_ff <= `RST_ROE;
			mode_b_ff <= selftest_mode_t'(`RST_BIST_SEL);
		end else begin
			rclk_pwr_b_ff <= nxt_rclk_pwr_b;
			mode_b_ff <= nxt_mode_b;
		end
	end

	// no read path exists at all
	assign recovered_clock_rate_sel = {rate_b_ff, rate_a_ff};
	assign half_rate_clock_mode = {half_b_ff, half_a_ff};
	assign primary_detect_amplitude = {det1_b_ff, det1_a_ff};
	assign secondary_detect_amplitude = {det2_b_ff, det2_a_ff};
	assign primary_detector_enable = {den1_b_ff, den1_a_ff};
	assign secondary_detector_enable = {den2_b_ff, den2_a_ff};
	assign training_clock_multiplier = {mult_b_ff, mult_a_ff};
	assign receive_channel_power_enable = {pwr_b_ff, pwr_a_ff};
	assign receive_selftest_select = {bist_b_ff, bist_a_ff};
	assign selftest_mode_a = mode_a_ff;
	assign selftest_mode_b = mode_b_ff;
	assign primary_retimed_out_enable = {roe1_b_ff, roe1_a_ff};
	assign secondary_retimed_out_enable = {roe2_b_ff, roe2_a_ff};
	assign reclocker_logic_power_enable = {rclk_pwr_b_ff, rclk_pwr_a_ff};
endmodule // config_latch_interface

`default_nettype wire

/* File: test/cfg_latch_sva.sv */
// Purpose: port checks for the configuration latch block
// Assumes: one clock, rstn asynchronous active low
// Notes: bound by name to every port
`timescale 1ns/10ps
`default_nettype none
module cfg_latch_sva (
	input wire logic clock,
	input wire logic rstn,
	input wire logic config_write_strobe_n,
	input wire logic [2:0] config_addr,
	input wire logic [6:0] config_data,
	input wire logic [1:0] recovered_clock_rate_sel,
	input wire logic [1:0] half_rate_clock_mode,
	input wire logic [3:0] primary_detect_amplitude,
	input wire logic [3:0] secondary_detect_amplitude,
	input wire logic [1:0] primary_detector_enable,
	input wire logic [1:0] secondary_detector_enable,
	input wire logic [1:0] training_clock_multiplier,
	input wire logic [1:0] receive_channel_power_enable,
	input wire logic [3:0] receive_selftest_select,
	input wire cfg_latch_pkg::selftest_mode_t selftest_mode_a,
	input wire cfg_latch_pkg::selftest_mode_t selftest_mode_b,
	input wire logic [1:0] primary_retimed_out_enable,
	input wire logic [1:0] secondary_retimed_out_enable,
	input wire logic [1:0] reclocker_logic_power_enable
);
	import cfg_latch_pkg::*;
	logic w;
	logic [33:0] outs;
	assign w = !config_write_strobe_n;
	assign outs = {recovered_clock_rate_sel, half_rate_clock_mode, primary_detect_amplitude,
		secondary_detect_amplitude, primary_detector_enable, secondary_detector_enable,
		training_clock_multiplier, receive_channel_power_enable, receive_selftest_select,
		selftest_mode_a, selftest_mode_b, primary_retimed_out_enable,
		secondary_retimed_out_enable, reclocker_logic_power_enable};
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	a_rate_write_a: assert property (w && config_addr == 3'h0 |=>
		recovered_clock_rate_sel[0] == $past(config_data[0])) else $error("rate A not latched");
	a_dyn_write_a: assert property (w && config_addr == 3'h2 |=>
		{receive_channel_power_enable[0], receive_selftest_select[1:0],
		secondary_retimed_out_enable[0], primary_retimed_out_enable[0]} ==
		$past({config_data[5], config_data[6], config_data[4], config_data[2:1]}))
		else $error("dynamic bank A not latched");
	a_static_b: assert property (w && config_addr == 3'h6 |=>
		{secondary_detect_amplitude[3:2], primary_detect_amplitude[3:2],
		training_clock_multiplier[1]} == $past({config_data[6:3], config_data[0]}))
		else $error("static bank B not latched");
	a_hold_idle: assert property (!w |=> $stable(outs)) else $error("idle changed a latch");
	a_test_ignored: assert property (w && config_addr inside {3'h3, 3'h4} |=>
		$stable(outs)) else $error("test address changed a latch");
	a_reset_values: assert property (disable iff (1'b0) !rstn |-> outs ==
		{2'h3, 2'h3, 4'hA, 4'hA, 2'h3, 2'h3, 2'h0, 2'h0, 4'hF, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0})
		else $error("reset values wrong");
	a_reclk_power: assert property (reclocker_logic_power_enable ==
		(primary_retimed_out_enable | secondary_retimed_out_enable)) else $error("reclocker power");
	a_mode_track: assert property (w ##1 !w |-> selftest_mode_b ==
		receive_selftest_select[3:2]) else $error("mode B mismatch");
	a_detect_enable: assert property (primary_detector_enable[0] ==
		|primary_detect_amplitude[1:0]) else $error("detector enable A");
	cover property (w && config_addr == 3'h7);
	cover property (w [*2]);
	cover property (reclocker_logic_power_enable == 2'h3);
endmodule // cfg_latch_sva
bind config_latch_interface cfg_latch_sva i_cfg_latch_sva (.*);
`default_nettype wire

/* File: test/cfg_host_model.sv */
// Purpose: host driving the configuration write port
// Assumes: callers pick legal values
// Notes: inputs change on rising edges only
`timescale 1ns/10ps
`default_nettype none
module cfg_host_model (
	input wire logic clock,
	output logic config_write_strobe_n,
	output logic [2:0] config_addr,
	output logic [6:0] config_data
);
	initial begin
		config_write_strobe_n = 1'h1;
		config_addr = 3'h0;
		config_data = 7'h00;
	end
	// strobe stays low across back-to-back puts
	task put(input logic [2:0] a, input logic [6:0] d);
		@(posedge clock);
		config_write_strobe_n <= 1'h0;
		config_addr <= a;
		config_data <= d;
	endtask
	// released lines flip so a stale word never looks valid
	task idle();
		@(posedge clock);
		config_write_strobe_n <= 1'h1;
		config_addr <= ~config_addr;
		config_data <= ~config_data;
	endtask
endmodule // cfg_host_model
`default_nettype wire

/* File: test/tb.sv */
// Purpose: self-checking bench for the configuration latches
// Assumes: speed select high, so multiplier 1 is legal
// Notes: expectations kept per channel from the bank layout
`timescale 1ns/10ps
`default_nettype none
module tb;
	import cfg_latch_pkg::*;
	logic clock, rstn, config_write_strobe_n;
	logic [2:0] config_addr;
	logic [6:0] config_data;
	logic [1:0] recovered_clock_rate_sel, half_rate_clock_mode, primary_detector_enable;
	logic [1:0] secondary_detector_enable, training_clock_multiplier, receive_channel_power_enable;
	logic [1:0] primary_retimed_out_enable, secondary_retimed_out_enable;
	logic [1:0] reclocker_logic_power_enable, rate, mult, pwr, roe1, roe2;
	logic [3:0] primary_detect_amplitude, secondary_detect_amplitude, receive_selftest_select;
	logic [3:0] amp1, amp2, bist;
	selftest_mode_t selftest_mode_a, selftest_mode_b;
	int err_total, compares;
	config_latch_interface i_config_latch_interface (.*);
	cfg_host_model i_cfg_host_model (.*);
	initial begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end
	task chk(input string n, input logic [33:0] e, input logic [33:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task check_all(input string n);
		@(negedge clock);
		chk(n, {rate, rate, amp1, amp2, |amp1[3:2], |amp1[1:0], |amp2[3:2], |amp2[1:0], mult, pwr,
			bist, bist[1:0], bist[3:2], roe1, roe2, roe1 | roe2}, {recovered_clock_rate_sel,
			half_rate_clock_mode, primary_detect_amplitude, secondary_detect_amplitude,
			primary_detector_enable, secondary_detector_enable, training_clock_multiplier,
			receive_channel_power_enable, receive_selftest_select, selftest_mode_a,
			selftest_mode_b, primary_retimed_out_enable, secondary_retimed_out_enable,
			reclocker_logic_power_enable});
	endtask
	task wr(input logic [2:0] a, input logic [6:0] d);
		int c;
		c = int'(a > 3'h4);
		i_cfg_host_model.put(a, d);
		case (a - 3'(5 * c))
		3'h0: rate[c] = d[0];
		3'h1: begin
			mult[c] = d[0];
			amp1[2*c+:2] = d[4:3];
			amp2[2*c+:2] = d[6:5];
		end
		3'h2: begin
			{pwr[c], roe2[c], roe1[c]} = {d[5], d[2], d[1]};
			bist[2*c+:2] = {d[6], d[4]};
		end
		default: ;
		endcase
	endtask
	task do_reset();
		@(posedge clock);
		rstn <= 1'h0;
		repeat (16) @(posedge clock);
		rstn <= 1'h1;
		{rate, amp1, amp2, mult, pwr, bist, roe1, roe2} =
			{2'h3, 4'hA, 4'hA, 2'h0, 2'h0, 4'hF, 2'h0, 2'h0};
		check_all("reset");
	endtask
	task t_chan_a();
		wr(3'h0, 7'h40);
		wr(3'h1, 7'h39);
		wr(3'h2, 7'h36);
		i_cfg_host_model.idle();
		check_all("chan_a");
	endtask
	task t_chan_b();
		wr(3'h5, 7'h41);
		wr(3'h6, 7'h00);
		wr(3'h7, 7'h62);
		wr(3'h3, 7'h7F);
		wr(3'h4, 7'h7F);
		i_cfg_host_model.idle();
		check_all("chan_b");
	endtask
	task t_codes();
		logic [6:0] dyn [4];
		dyn = '{7'h12, 7'h44, 7'h10, 7'h66};
		for (int i = 0; i < 4; i++) begin
			wr(3'h1, 7'(i * 20));
			wr(3'h2, dyn[i]);
			i_cfg_host_model.idle();
			check_all("codes");
		end
	endtask
	task report_and_stop();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		// starts high so the first reset is a real falling edge at a clock edge
		rstn = 1'h1;
		err_total = 0;
		compares = 0;
		do_reset();
		t_chan_a();
		t_chan_b();
		t_codes();
		do_reset();
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
